// File: pkg/ca_pkg.sv
// Constants, field layout and carrier types of the counter array watchdog
`default_nettype none

package ca_pkg;

  // Special function register map
  localparam logic [7:0] PAGE_MAIN   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'hD8;
  localparam logic [7:0] ADDR_MODE   = 8'hD9;
  localparam logic [7:0] ADDR_CNT_LO = 8'hF9;
  localparam logic [7:0] ADDR_CNT_HI = 8'hFA;
  localparam logic [7:0] ADDR_MODE2  = 8'hDC;
  localparam logic [7:0] ADDR_OFFSET = 8'hEC;
  localparam logic [7:0] ADDR_UPDATE = 8'hED;

  // Control register fields
  localparam int         CTRL_CF     = 7;
  localparam int         CTRL_CR     = 6;
  localparam int         CTRL_THIRD_MODULE_FLAG   = 2;
  localparam int         CCF_W       = 3;
  localparam logic [2:0] RSVD_READ   = 3'h0;

  // Mode register fields
  localparam int         MODE_ECCF   = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [7:0]  OFFSET_RESET = 8'h00;
  localparam logic [7:0]  UPDATE_RESET = 8'h00;
  localparam logic [7:0]  MODE2_RESET  = 8'h00;
  localparam logic [3:0]  OSC_DIV_RESET = 4'h8;

  // Counter clock source codes
  localparam logic [2:0] CPS_DIV12  = 3'h0;
  localparam logic [2:0] CPS_DIV4   = 3'h1;
  localparam logic [2:0] CPS_EXT    = 3'h3;
  localparam logic [2:0] CPS_SYSCLK = 3'h4;

  // Prescaler ratios
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;

  // Counter extremes
  localparam logic [7:0]  BYTE_MAX = 8'hFF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // One register bus access
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [2:0] bit_idx;
    logic       bit_val;
  } sfr_req_t;

  // Counter mode register layout, bit 4 reads zero
  typedef struct packed {
    logic       idle_suspend_bit;
    logic       watchdog_enable_bit;
    logic       watchdog_lock_bit;
    logic       zero;
    logic [2:0] cps;
    logic       ecf;
  } mode_t;

  localparam mode_t MODE_RESET = '{idle_suspend_bit: 1'b0, watchdog_enable_bit: 1'b1, watchdog_lock_bit: 1'b0,
                                   zero: 1'b0, cps: CPS_DIV12, ecf: 1'b0};

endpackage : ca_pkg

`default_nettype wire

// File: test/counter_array_watchdog_ctrl_tb.sv
// Self-checking bench for the counter array watchdog and control register
`default_nettype none

module counter_array_watchdog_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             mclk;
  logic             reset;
  ca_pkg::sfr_req_t req;
  logic             cpu_idle;
  logic             ext_clk_pin;
  logic [2:0]       module_event;
  logic [1:0]       module_int_en;
  logic [7:0]       sfr_rdata;
  logic             counter_irq;
  logic             watchdog_reset;
  logic [3:0]       osc_div_code;
  logic             watchdog_active;
  logic [7:0]       exp_q[$];
  logic             rd_pend;
  int               num_errors;
  int               cmp_count;
  int               cycles;
  logic [7:0]       lo_r;
  logic [2:0]       ev;

  counter_array_watchdog dut (
    .mclk            (mclk),
    .reset           (reset),
    .sfr_req         (req),
    .cpu_idle        (cpu_idle),
    .ext_clk_pin     (ext_clk_pin),
    .module_event    (module_event),
    .module_int_en   (module_int_en),
    .sfr_rdata       (sfr_rdata),
    .counter_irq     (counter_irq),
    .watchdog_reset  (watchdog_reset),
    .osc_div_code    (osc_div_code),
    .watchdog_active (watchdog_active)
  );

  // Clock at 25 ns
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Read data holds until the next read, so compare one edge later
  always @(posedge mclk) begin
    if (rd_pend) begin
      check(16'(sfr_rdata), 16'(exp_q.pop_front()));
    end
    rd_pend <= req.rd;
  end

  // Byte write, held for one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge mclk);
    req.wr    <= 1'b0;
  endtask

  // Read with expected value noted for the monitor
  task automatic rd(input logic [7:0] pg, input logic [7:0] a,
                    input logic [7:0] e);
    @(posedge mclk);
    req.page <= pg;
    req.addr <= a;
    req.rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    req.rd   <= 1'b0;
    req.page <= ca_pkg::PAGE_MAIN;
  endtask

  // Single bit write to the control register
  task automatic bwr(input logic [2:0] idx, input logic v);
    @(posedge mclk);
    req.addr    <= ca_pkg::ADDR_CTRL;
    req.bit_idx <= idx;
    req.bit_val <= v;
    req.bit_wr  <= 1'b1;
    @(posedge mclk);
    req.bit_wr  <= 1'b0;
  endtask

  task automatic idle_cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    idle_cycles(6);
    reset <= 1'b0;
  endtask

  // Cycles until the reset request, bounded
  task automatic wait_wdr(output int c);
    c = 0;
    @(negedge mclk);
    while (watchdog_reset !== 1'b1 && c < 4000) begin
      @(negedge mclk);
      c++;
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, about five times the expected run
  initial begin
    #500000;
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    req = '0;
    cpu_idle = 1'b0;
    ext_clk_pin = 1'b0;
    module_event = 3'h0;
    module_int_en = 2'h0;
    rd_pend = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(74));
    do_reset();
    check(16'(osc_div_code), 16'(ca_pkg::OSC_DIV_RESET));
    check(16'(watchdog_active), 16'h0001);
    // Default timeout of 256 ticks at twelve cycles each
    wait_wdr(cycles);
    check(16'(cycles >= 3050 && cycles <= 3100), 16'h0001);
    @(negedge mclk);
    check(16'(watchdog_reset), 16'h0000);
    do_reset();
    rd(8'h00, ca_pkg::ADDR_MODE, 8'h40);
    rd(8'h00, ca_pkg::ADDR_CTRL, 8'h00);
    rd(8'h00, ca_pkg::ADDR_OFFSET, 8'h00);
    wr(ca_pkg::ADDR_MODE, 8'hC8);
    wr(ca_pkg::ADDR_CNT_HI, 8'h80);
    rd(8'h00, ca_pkg::ADDR_MODE, 8'h40);
    wr(ca_pkg::ADDR_MODE, 8'h00);
    rd(8'h00, ca_pkg::ADDR_CNT_HI, 8'h00);
    check(16'(watchdog_active), 16'h0000);
    // Stopped counter, update loads high byte plus offset
    lo_r = 8'($urandom_range(127, 0));
    wr(ca_pkg::ADDR_CNT_LO, lo_r);
    wr(ca_pkg::ADDR_CNT_HI, 8'h05);
    wr(ca_pkg::ADDR_OFFSET, 8'h02);
    wr(ca_pkg::ADDR_UPDATE, 8'h99);
    rd(8'h00, ca_pkg::ADDR_UPDATE, 8'h07);
    rd(8'h00, ca_pkg::ADDR_CNT_LO, lo_r);
    // Configuration order with a fast clock
    wr(ca_pkg::ADDR_MODE, 8'h08);
    wr(ca_pkg::ADDR_OFFSET, 8'h02);
    wr(ca_pkg::ADDR_MODE, 8'h48);
    wr(ca_pkg::ADDR_UPDATE, 8'h00);
    rd(8'h00, ca_pkg::ADDR_UPDATE, 8'h07);
    rd(8'h00, ca_pkg::ADDR_MODE, 8'h48);
    wait_wdr(cycles);
    check(16'(cycles >= 600 && cycles <= 800), 16'h0001);
    wr(ca_pkg::ADDR_MODE, 8'h00);
    @(negedge mclk);
    check(16'(watchdog_active), 16'h0000);
    // Overflow flag, run bit and unused bits
    wr(ca_pkg::ADDR_MODE, 8'h09);
    wr(ca_pkg::ADDR_CNT_LO, 8'hF0);
    wr(ca_pkg::ADDR_CNT_HI, 8'hFF);
    wr(ca_pkg::ADDR_CTRL, 8'h40);
    idle_cycles(40);
    rd(8'h00, ca_pkg::ADDR_CTRL, 8'hC0);
    check(16'(counter_irq), 16'h0001);
    wr(ca_pkg::ADDR_CTRL, 8'h38);
    rd(8'h00, ca_pkg::ADDR_CTRL, 8'h00);
    check(16'(counter_irq), 16'h0000);
    wr(ca_pkg::ADDR_CNT_LO, 8'h20);
    idle_cycles(30);
    rd(8'h00, ca_pkg::ADDR_CNT_LO, 8'h20);
    // Idle suspend holds the count
    wr(ca_pkg::ADDR_MODE, 8'h88);
    cpu_idle <= 1'b1;
    wr(ca_pkg::ADDR_CNT_LO, 8'h00);
    wr(ca_pkg::ADDR_CTRL, 8'h40);
    idle_cycles(30);
    wr(ca_pkg::ADDR_CTRL, 8'h00);
    cpu_idle <= 1'b0;
    rd(8'h00, ca_pkg::ADDR_CNT_LO, 8'h00);
    // Module event flags and their interrupt
    ev = 3'($urandom_range(7, 1));
    module_int_en <= 2'b11;
    wr(ca_pkg::ADDR_MODE2, 8'h01);
    module_event <= ev;
    @(posedge mclk);
    module_event <= 3'h0;
    rd(8'h00, ca_pkg::ADDR_CTRL, {5'h00, ev});
    check(16'(counter_irq), 16'h0001);
    wr(ca_pkg::ADDR_CTRL, 8'h00);
    rd(8'h00, ca_pkg::ADDR_CTRL, 8'h00);
    rd(8'h00, 8'hA0, 8'h00);
    rd(8'h01, ca_pkg::ADDR_MODE, 8'h00);
    // Lock, forced reset, then reset clears the lock
    wr(ca_pkg::ADDR_MODE, 8'h00);
    wr(ca_pkg::ADDR_MODE, 8'h20);
    @(negedge mclk);
    check(16'(watchdog_active), 16'h0001);
    wr(ca_pkg::ADDR_MODE, 8'h00);
    rd(8'h00, ca_pkg::ADDR_MODE, 8'h20);
    check(16'(watchdog_active), 16'h0001);
    bwr(3'(ca_pkg::CTRL_THIRD_MODULE_FLAG), 1'b1);
    wait_wdr(cycles);
    check(16'(cycles <= 2), 16'h0001);
    do_reset();
    rd(8'h00, ca_pkg::ADDR_MODE, 8'h40);
    wr(ca_pkg::ADDR_MODE, 8'h00);
    @(negedge mclk);
    check(16'(watchdog_active), 16'h0000);
    idle_cycles(4);
    finish_test();
  end

endmodule // counter_array_watchdog_ctrl_tb

`default_nettype wire

// File: verilog/counter_array_watchdog.sv
// Counter array control, status and watchdog built on its third module
`default_nettype none

module counter_array_watchdog (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire ca_pkg::sfr_req_t sfr_req,
  input  wire logic             cpu_idle,
  input  wire logic             ext_clk_pin,
  input  wire logic [2:0]       module_event,
  input  wire logic [1:0]       module_int_en,
  output logic [7:0]            sfr_rdata,
  output logic                  counter_irq,
  output logic                  watchdog_reset,
  output logic [3:0]            osc_div_code,
  output logic                  watchdog_active
);

  localparam int NFLAG = ca_pkg::CCF_W + 1;

  // Page and address decode
  function automatic logic hit(input ca_pkg::sfr_req_t r,
                               input logic [7:0] a);
    hit = (r.page == ca_pkg::PAGE_MAIN) && (r.addr == a);
  endfunction

  // Byte write or single bit write merged onto current value
  function automatic logic [7:0] merge(input ca_pkg::sfr_req_t r,
                                       input logic [7:0] cur);
    logic [7:0] v;
    v = cur;
    if (r.bit_wr) begin
      v[r.bit_idx] = r.bit_val;
    end else begin
      v = r.wdata;
    end
    merge = v;
  endfunction

  ca_pkg::mode_t mode;
  ca_pkg::mode_t next_mode;
  logic [15:0]   cnt;
  logic [15:0]   next_cnt;
  logic          run;
  logic          next_run;
  logic [7:0]    offset;
  logic [7:0]    next_offset;
  logic [7:0]    update;
  logic [7:0]    next_update;
  logic [7:0]    mode2;
  logic [7:0]    next_mode2;
  logic [7:0]    next_rdata;
  logic          next_irq;
  logic          next_wd_reset;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] flag_set;
  logic [NFLAG-1:0] flag_wval;
  logic [7:0]    ctrl_rd;
  logic [7:0]    ctrl_wv;
  logic [7:0]    mode_wv;
  logic          any_wr;
  logic          wr_ctrl;
  logic          wr_mode;
  logic          wd_en;
  logic          tick;
  logic          inc;
  logic          lo_ovf;
  logic          full_ovf;
  logic          expire;
  logic          force_rst;

  // Counter clock source
  counter_prescaler u_prescaler (
    .mclk    (mclk),
    .reset   (reset),
    .sel     (mode.cps),
    .ext_pin (ext_clk_pin),
    .tick    (tick)
  );

  // Overflow flag on top, module flags below
  sticky_flags #(.N(NFLAG)) u_flags (
    .mclk   (mclk),
    .reset  (reset),
    .set    (flag_set),
    .wr     (wr_ctrl),
    .wr_val (flag_wval),
    .q      (flags)
  );

  // Decode and status views
  always_comb begin
    any_wr  = sfr_req.wr | sfr_req.bit_wr;
    wr_ctrl = any_wr & hit(sfr_req, ca_pkg::ADDR_CTRL);
    wr_mode = sfr_req.wr & hit(sfr_req, ca_pkg::ADDR_MODE);
    wd_en   = mode.watchdog_enable_bit | mode.watchdog_lock_bit;
    ctrl_rd = {flags[ca_pkg::CCF_W], run, ca_pkg::RSVD_READ,
               flags[ca_pkg::CCF_W-1:0]};
    ctrl_wv = merge(sfr_req, ctrl_rd);
    mode_wv = sfr_req.wdata;
  end

  // Counting and event detection
  always_comb begin
    inc      = (run | wd_en) & tick & ~(mode.idle_suspend_bit & cpu_idle);
    lo_ovf   = inc & (cnt[7:0] == ca_pkg::BYTE_MAX);
    full_ovf = inc & (cnt == ca_pkg::CNT_MAX);
    expire   = wd_en & lo_ovf & (cnt[15:8] == update);
    force_rst = wd_en & wr_ctrl & ctrl_wv[ca_pkg::CTRL_THIRD_MODULE_FLAG];
    flag_set  = {full_ovf, module_event};
    flag_wval = {ctrl_wv[ca_pkg::CTRL_CF], ctrl_wv[ca_pkg::CCF_W-1:0]};
  end

  // Next values of the register file
  always_comb begin
    next_mode   = mode;
    next_cnt    = inc ? cnt + 16'h0001 : cnt;
    next_run    = run;
    next_offset = offset;
    next_update = update;
    next_mode2  = mode2;
    if (wr_ctrl) begin
      next_run = ctrl_wv[ca_pkg::CTRL_CR];
    end
    if (wr_mode) begin
      next_mode.ecf   = mode_wv[0];
      next_mode.watchdog_lock_bit = mode.watchdog_lock_bit | mode_wv[5];
      if (!mode.watchdog_lock_bit) begin
        next_mode.watchdog_enable_bit = mode_wv[6];
      end
      if (!wd_en) begin
        next_mode.cps  = mode_wv[3:1];
        next_mode.idle_suspend_bit = mode_wv[7];
      end
    end
    next_mode.zero = 1'b0;
    if (sfr_req.wr && !wd_en) begin
      if (hit(sfr_req, ca_pkg::ADDR_CNT_LO)) begin
        next_cnt[7:0] = sfr_req.wdata;
      end
      if (hit(sfr_req, ca_pkg::ADDR_CNT_HI)) begin
        next_cnt[15:8] = sfr_req.wdata;
      end
      if (hit(sfr_req, ca_pkg::ADDR_MODE2)) begin
        next_mode2 = sfr_req.wdata;
      end
    end
    if (sfr_req.wr && hit(sfr_req, ca_pkg::ADDR_OFFSET)) begin
      next_offset = sfr_req.wdata;
    end
    if (sfr_req.wr && hit(sfr_req, ca_pkg::ADDR_UPDATE)) begin
      next_update = cnt[15:8] + offset;
    end
  end

  // Read data, interrupt request and reset pulse
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_req.rd) begin
      next_rdata = 8'h00;
      if (hit(sfr_req, ca_pkg::ADDR_CTRL))   next_rdata = ctrl_rd;
      if (hit(sfr_req, ca_pkg::ADDR_MODE))   next_rdata = mode;
      if (hit(sfr_req, ca_pkg::ADDR_CNT_LO)) next_rdata = cnt[7:0];
      if (hit(sfr_req, ca_pkg::ADDR_CNT_HI)) next_rdata = cnt[15:8];
      if (hit(sfr_req, ca_pkg::ADDR_MODE2))  next_rdata = mode2;
      if (hit(sfr_req, ca_pkg::ADDR_OFFSET)) next_rdata = offset;
      if (hit(sfr_req, ca_pkg::ADDR_UPDATE)) next_rdata = update;
    end
    next_irq = (flags[ca_pkg::CCF_W] & mode.ecf)
             | (flags[2] & mode2[ca_pkg::MODE_ECCF])
             | (|(flags[1:0] & module_int_en));
    next_wd_reset = expire | force_rst;
  end

  // Register file and outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode            <= ca_pkg::MODE_RESET;
      cnt             <= ca_pkg::CNT_RESET;
      run             <= ca_pkg::CTRL_RESET[ca_pkg::CTRL_CR];
      offset          <= ca_pkg::OFFSET_RESET;
      update          <= ca_pkg::UPDATE_RESET;
      mode2           <= ca_pkg::MODE2_RESET;
      sfr_rdata       <= 8'h00;
      counter_irq     <= 1'b0;
      watchdog_reset  <= 1'b0;
      osc_div_code    <= ca_pkg::OSC_DIV_RESET;
      watchdog_active <= 1'b1;
    end else begin
      mode            <= next_mode;
      cnt             <= next_cnt;
      run             <= next_run;
      offset          <= next_offset;
      update          <= next_update;
      mode2           <= next_mode2;
      sfr_rdata       <= next_rdata;
      counter_irq     <= next_irq;
      watchdog_reset  <= next_wd_reset;
      osc_div_code    <= osc_div_code;
      watchdog_active <= next_mode.watchdog_enable_bit | next_mode.watchdog_lock_bit;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence lock_write_zero;
    wr_mode && mode.watchdog_lock_bit && !mode_wv[6];
  endsequence

  sequence frozen_write;
    wr_mode && wd_en;
  endsequence

  wd_out_of_reset_a: assert property ($fell(reset) |-> wd_en
    && (mode.cps == ca_pkg::CPS_DIV12) && (offset == 8'h00))
    else $error("watchdog not enabled with defaults after reset");

  lock_holds_a: assert property (lock_write_zero |=> wd_en
    && mode.watchdog_lock_bit)
    else $error("locked watchdog was disabled");

  unlock_disable_a: assert property (wr_mode && !mode.watchdog_lock_bit
    && !mode_wv[6] && !mode_wv[5] |=> !wd_en)
    else $error("unlocked watchdog not disabled");

  clk_frozen_a: assert property (frozen_write |=> $stable(mode.cps)
    && $stable(mode.idle_suspend_bit))
    else $error("clock or idle select changed while enabled");

  update_load_a: assert property (sfr_req.wr
    && hit(sfr_req, ca_pkg::ADDR_UPDATE)
    |=> update == $past(cnt[15:8]) + $past(offset))
    else $error("update register load wrong");

  expire_pulse_a: assert property (expire |=> watchdog_reset
    ##1 (!watchdog_reset || $past(next_wd_reset)))
    else $error("watchdog expiry did not pulse reset");

  force_reset_a: assert property (force_rst |=> watchdog_reset)
    else $error("forced watchdog reset missing");

  no_reset_idle_a: assert property (!wd_en |=> !watchdog_reset)
    else $error("reset pulse while watchdog disabled");

  overflow_flag_a: assert property (full_ovf |=> flags[ca_pkg::CCF_W])
    else $error("overflow flag not set on wrap");

  rsvd_zero_a: assert property (sfr_req.rd
    && hit(sfr_req, ca_pkg::ADDR_CTRL) |=> sfr_rdata[5:3] == 3'h0)
    else $error("reserved control bits not zero");

  cnt_blocked_a: assert property (wd_en && sfr_req.wr
    && hit(sfr_req, ca_pkg::ADDR_CNT_HI) && !inc |=> $stable(cnt))
    else $error("counter written while watchdog enabled");

  idle_pause_a: assert property (mode.idle_suspend_bit && cpu_idle |=>
    $stable(cnt) || $past(sfr_req.wr))
    else $error("counter advanced in idle with suspend set");

endmodule // counter_array_watchdog

`default_nettype wire

// File: verilog/counter_prescaler.sv
// Counter clock tick generator from the selected source
`default_nettype none

module counter_prescaler (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] sel,
  input  wire logic       ext_pin,
  output logic            tick
);

  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic       sync_a;
  logic       sync_b;
  logic       sync_c;
  logic       next_tick;

  // Shared divider, every fourth count gives the quarter rate
  always_comb begin
    next_div_cnt = (div_cnt == ca_pkg::DIV12_LAST) ? 4'h0 : div_cnt + 4'h1;
    unique case (sel)
      ca_pkg::CPS_DIV12:  next_tick = (div_cnt == ca_pkg::DIV12_LAST);
      ca_pkg::CPS_DIV4:   next_tick = (div_cnt[1:0] == ca_pkg::DIV4_LAST);
      ca_pkg::CPS_EXT:    next_tick = sync_b & ~sync_c;
      ca_pkg::CPS_SYSCLK: next_tick = 1'b1;
      default:            next_tick = 1'b0;
    endcase
  end

  // Divider, pin synchroniser and tick register
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_cnt <= 4'h0;
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      sync_c  <= 1'b0;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      sync_a  <= ext_pin;
      sync_b  <= sync_a;
      sync_c  <= sync_b;
      tick    <= next_tick;
    end
  end

endmodule // counter_prescaler

`default_nettype wire

// File: verilog/sticky_flags.sv
// Sticky event flags, hardware set wins over software write
`default_nettype none

module sticky_flags #(
  parameter int N = 4
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [N-1:0] set,
  input  wire logic         wr,
  input  wire logic [N-1:0] wr_val,
  output logic [N-1:0]      q
);

  logic [N-1:0] next_q;

  // Software value or hold, then OR in new events
  always_comb begin
    next_q = (wr ? wr_val : q) | set;
  end

  // Flag storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule // sticky_flags

`default_nettype wire
